// file: dv/rmo_ctrl_assertions.sv
// checker: timing relations on the remote output control ports
`timescale 1ns/1ns
module rmo_ctrl_assertions (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        power_on_reset,
	input wire logic        soft_reset,
	input wire logic        reg_wr,
	input wire logic [1:0]  reg_addr,
	input wire logic [11:0] reg_wdata,
	input wire logic        ext_fitted,
	input wire logic        relay_fitted,
	input wire logic [11:0] nv_word_one,
	input wire logic [7:0]  retention_select,
	input wire logic [11:0] remote_word_one,
	input wire logic [11:0] remote_word_two,
	input wire logic        ready,
	input wire logic [6:0]  extension_outputs,
	input wire logic [2:0]  relay_outputs
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire       rst_ev = power_on_reset | soft_reset;
	wire       keep_r = retention_select == 8'h0a || retention_select == 8'h0b;
	wire       wr_ok  = reg_wr & ready & ~rst_ev;
	wire       sel_ok = reg_wdata[11:2] == 10'h000 || reg_wdata[11:1] == 11'h005;
	wire [6:0] ext_x  = (remote_word_one[6:0] | remote_word_two[6:0]) & {7{ext_fitted}};
	wire [2:0] rly_x  = (remote_word_one[9:7] | remote_word_two[9:7]) & {3{relay_fitted}};
	////////////////////////////////////////////////////////////////////////////////
	property p_w1; wr_ok && reg_addr == 2'h1 |=> remote_word_one == $past(reg_wdata); endproperty
	a_w1: assert property (p_w1) else $error("word one readback wrong");
	property p_w2; wr_ok && reg_addr == 2'h2 |=> remote_word_two == $past(reg_wdata); endproperty
	a_w2: assert property (p_w2) else $error("word two readback wrong");
	property p_sel; wr_ok && reg_addr == 2'h0 && sel_ok |=> retention_select[3:0] == $past(reg_wdata[3:0]); endproperty
	a_sel: assert property (p_sel) else $error("select not taken");
	property p_bad; reg_wr && reg_addr == 2'h0 && !sel_ok |=> $stable(retention_select); endproperty
	a_bad: assert property (p_bad) else $error("bad select taken");
	property p_ext; 1'b1 |=> extension_outputs == $past(ext_x); endproperty
	a_ext: assert property (p_ext) else $error("extension outputs wrong");
	property p_rly; 1'b1 |=> relay_outputs == $past(rly_x); endproperty
	a_rly: assert property (p_rly) else $error("relay outputs wrong");
	property p_clr; power_on_reset && !retention_select[0] |=> remote_word_one == 12'h000 && remote_word_two == 12'h000; endproperty
	a_clr: assert property (p_clr) else $error("words kept at power up");
	property p_nv; power_on_reset && retention_select[0] |=> remote_word_one == $past(nv_word_one); endproperty
	a_nv: assert property (p_nv) else $error("word not restored");
	property p_sr; soft_reset && !power_on_reset && !keep_r |=> remote_word_two == 12'h000; endproperty
	a_sr: assert property (p_sr) else $error("word kept at reset");
	property p_rdy; rst_ev |=> !ready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready stayed high");
	c_keep: cover property (soft_reset && keep_r);
	c_nv: cover property (power_on_reset && retention_select[0]);
	c_w2: cover property (wr_ok && reg_addr == 2'h2);
endmodule : rmo_ctrl_assertions

// file: dv/rmo_host.sv
// partner: host writing the device registers over its link
`timescale 1ns/1ns
module rmo_host (
	input  wire logic   core_clk,
	output logic        reg_wr,
	output logic [1:0]  reg_addr,
	output logic [11:0] reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_addr = 2'h0;
		reg_wdata = 12'h000;
	end
	// one-cycle strobe; released data shows the inverse so stale values never look valid
	task automatic wr(input logic [1:0] a, input logic [11:0] d);
		@(posedge core_clk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge core_clk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask : wr
endmodule : rmo_host

// file: dv/test_remote_output_control.sv
// testbench: remote output control block
`timescale 1ns/1ns
module test_remote_output_control;
	logic core_clk = 1'b0, rst_n = 1'b0, power_on_reset = 1'b0, soft_reset = 1'b0;
	logic power_fail = 1'b0, write_protect_select = 1'b0, reg_wr, nv_save, ready;
	logic ext_fitted = 1'b0, relay_fitted = 1'b1;
	logic [1:0] reg_addr;
	logic [2:0] assigned_func_level = 3'h0, assigned_terminals, relay_outputs;
	logic [6:0] extension_outputs;
	logic [7:0] output_terminal_assign [3] = '{8'h60, 8'hc4, 8'h00};
	logic [7:0] retention_select;
	logic [11:0] reg_wdata, remote_word_one, remote_word_two;
	logic [11:0] nv_word_one = 12'h123, nv_word_two = 12'h456;
	int err_total = 0, checked = 0, cyc = 0;
	logic [7:0] sels [4] = '{8'h00, 8'h01, 8'h0a, 8'h0b};
	rmo_ctrl uut (
		.core_clk               (core_clk),
		.rst_n                  (rst_n),
		.power_on_reset         (power_on_reset),
		.soft_reset             (soft_reset),
		.power_fail             (power_fail),
		.reg_wr                 (reg_wr),
		.reg_addr               (reg_addr),
		.reg_wdata              (reg_wdata),
		.write_protect_select   (write_protect_select),
		.output_terminal_assign (output_terminal_assign),
		.assigned_func_level    (assigned_func_level),
		.ext_fitted             (ext_fitted),
		.relay_fitted           (relay_fitted),
		.nv_word_one            (nv_word_one),
		.nv_word_two            (nv_word_two),
		.retention_select       (retention_select),
		.remote_word_one        (remote_word_one),
		.remote_word_two        (remote_word_two),
		.nv_save                (nv_save),
		.ready                  (ready),
		.assigned_terminals     (assigned_terminals),
		.extension_outputs      (extension_outputs),
		.relay_outputs          (relay_outputs)
	);
	rmo_host u_host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
	initial forever #5 core_clk = ~core_clk;
	always @(posedge core_clk) if (++cyc == 3000) begin
		err_total++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_rdy();
		repeat (2) @(posedge core_clk);
		#1;
		for (int i = 0; i < 20 && ready !== 1'b1; i++) begin
			@(posedge core_clk);
			#1;
		end
	endtask : wait_rdy
	task automatic pulse(input logic pwr);
		@(posedge core_clk);
		#1;
		if (pwr) power_on_reset = 1'b1; else soft_reset = 1'b1;
		@(posedge core_clk);
		#1;
		power_on_reset = 1'b0;
		soft_reset = 1'b0;
		wait_rdy();
	endtask : pulse
	task automatic t_words();
		u_host.wr(2'h1, 12'hfff);
		u_host.wr(2'h2, 12'h000);
		@(posedge core_clk);
		#1;
		chk(remote_word_one, 12'hfff);
		chk(extension_outputs, 12'h000);
		chk(relay_outputs, 12'h007);
		ext_fitted = 1'b1;
		u_host.wr(2'h1, 12'h001);
		assigned_func_level = 3'h4;
		@(posedge core_clk);
		#1;
		chk(extension_outputs, 12'h001);
		chk(assigned_terminals, 12'h007);
		u_host.wr(2'h1, 12'h002);
		assigned_func_level = 3'h0;
		@(posedge core_clk);
		#1;
		chk(assigned_terminals, 12'h000);
		u_host.wr(2'h2, 12'h380);
		relay_fitted = 1'b0;
		@(posedge core_clk);
		#1;
		chk(relay_outputs, 12'h000);
		relay_fitted = 1'b1;
	endtask : t_words
	task automatic t_keep();
		foreach (sels[i]) begin
			u_host.wr(2'h0, {4'h0, sels[i]});
			u_host.wr(2'h2, 12'h05a);
			pulse(1'b0);
			chk(retention_select, sels[i]);
			chk(remote_word_two, sels[i][3] ? 12'h05a : 12'h000);
			pulse(1'b1);
			chk(remote_word_one, sels[i][0] ? 12'h123 : 12'h000);
			chk(extension_outputs, sels[i][0] ? 12'h077 : 12'h000);
		end
		u_host.wr(2'h0, 12'h005);
		u_host.wr(2'h0, 12'h10a);
		@(posedge core_clk);
		#1;
		chk(retention_select, 12'h00b);
	endtask : t_keep
	task automatic t_save();
		@(posedge core_clk);
		#1;
		power_fail = 1'b1;
		@(posedge core_clk);
		#1;
		chk(nv_save, 12'h001);
		@(posedge core_clk);
		#1;
		chk(nv_save, 12'h000);
		power_fail = 1'b0;
		u_host.wr(2'h0, 12'h000);
		power_fail = 1'b1;
		@(posedge core_clk);
		#1;
		chk(nv_save, 12'h000);
		power_fail = 1'b0;
	endtask : t_save
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (20) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		wait_rdy();
		chk(retention_select, 12'h000);
		chk(remote_word_two, 12'h000);
		t_words();
		t_keep();
		t_save();
		wrap_up();
	end
endmodule : test_remote_output_control
bind rmo_ctrl rmo_ctrl_assertions u_chk (
	.core_clk          (core_clk),
	.rst_n             (rst_n),
	.power_on_reset    (power_on_reset),
	.soft_reset        (soft_reset),
	.reg_wr            (reg_wr),
	.reg_addr          (reg_addr),
	.reg_wdata         (reg_wdata),
	.ext_fitted        (ext_fitted),
	.relay_fitted      (relay_fitted),
	.nv_word_one       (nv_word_one),
	.retention_select  (retention_select),
	.remote_word_one   (remote_word_one),
	.remote_word_two   (remote_word_two),
	.ready             (ready),
	.extension_outputs (extension_outputs),
	.relay_outputs     (relay_outputs)
);

// file: logic/rmo_ctrl.sv
// module: remote output control with retention across power loss and reset
`timescale 1ns/1ns
// How it works
// [R1] retention select takes 0, 1, 10 or 11 choosing power and reset retention
// [R2] two twelve-bit data words, range 0 to 4095, start at zero
// [R3] bits 0 to 6 drive extension outputs only when that hardware is fitted
// [R4] bits 7 to 9 drive relays when fitted; bits 10 and 11 ignored
// [R5] terminal follows the words only when assigned code 96 or 196
// [R6] bit 1 turns terminal on, 0 off; negative logic inverts
// [R7] terminals not assigned remote drive keep their own function
// [R8] selection 0 or 10: power-on reset clears words and outputs
// [R9] selection 1 or 11: words saved at power loss, restored at power-up
// [R10] soft reset clears words unless selection is 10 or 11
// [R11] words writable while running regardless of write protection
// [R12] host changes outputs by writing the words over its link
// [R13] restored or cleared values reach terminals before reset sequence ends
module rmo_ctrl (
	input  wire logic                          core_clk,
	input  wire logic                          rst_n,
	input  wire logic                          power_on_reset,
	input  wire logic                          soft_reset,
	input  wire logic                          power_fail,
	input  wire logic                          reg_wr,
	input  wire logic [1:0]                    reg_addr,
	input  wire logic [rmo_pkg::WORD_W-1:0]    reg_wdata,
	input  wire logic                          write_protect_select,
	input  wire logic [rmo_pkg::FUNC_W-1:0]    output_terminal_assign [rmo_pkg::N_ASSIGN],
	input  wire logic [rmo_pkg::N_ASSIGN-1:0]  assigned_func_level,
	input  wire logic                          ext_fitted,
	input  wire logic                          relay_fitted,
	input  wire logic [rmo_pkg::WORD_W-1:0]    nv_word_one,
	input  wire logic [rmo_pkg::WORD_W-1:0]    nv_word_two,
	output logic      [rmo_pkg::SEL_W-1:0]     retention_select,
	output logic      [rmo_pkg::WORD_W-1:0]    remote_word_one,
	output logic      [rmo_pkg::WORD_W-1:0]    remote_word_two,
	output logic                               nv_save,
	output logic                               ready,
	output logic      [rmo_pkg::N_ASSIGN-1:0]  assigned_terminals,
	output logic      [rmo_pkg::EXT_N-1:0]     extension_outputs,
	output logic      [rmo_pkg::RLY_N-1:0]     relay_outputs
);
	////////////////////////////////////////////////////////////////////////
	rmo_pkg::rmo_state_t state;
	logic        keep_pwr;
	logic        keep_rst;
	logic        fail_d;
	logic        sel_ok;
	logic        wr_run;
	logic        wr_one;
	logic        wr_two;
	logic [rmo_pkg::TERM_W-1:0]   fitted;
	logic [rmo_pkg::N_ASSIGN-1:0] next_assign;
	logic [rmo_pkg::TERM_W-1:0]   next_term;

	////////////////////////////////////////////////////////////////////////
	// select decoding; the codes are read in three places, so they live in functions
	function automatic logic sel_valid(input logic [rmo_pkg::WORD_W-1:0] d);
		logic [rmo_pkg::SEL_W-1:0] s;
		s = d[rmo_pkg::SEL_W-1:0];
		// the upper data bits must be clear, whatever the low byte holds
		sel_valid = ((s == rmo_pkg::SEL_CLR_ALL)
			|| (s == rmo_pkg::SEL_KEEP_PWR)
			|| (s == rmo_pkg::SEL_KEEP_RST)
			|| (s == rmo_pkg::SEL_KEEP_BOTH))
			&& (d[rmo_pkg::WORD_W-1:rmo_pkg::SEL_W] == '0); // [R1]
	endfunction : sel_valid

	function automatic logic sel_keeps_power(input logic [rmo_pkg::SEL_W-1:0] s);
		sel_keeps_power = (s == rmo_pkg::SEL_KEEP_PWR) || (s == rmo_pkg::SEL_KEEP_BOTH);
	endfunction : sel_keeps_power

	function automatic logic sel_keeps_reset(input logic [rmo_pkg::SEL_W-1:0] s);
		sel_keeps_reset = (s == rmo_pkg::SEL_KEEP_RST) || (s == rmo_pkg::SEL_KEEP_BOTH);
	endfunction : sel_keeps_reset

	// next value of one data word; power-on reset beats soft reset beats a write
	function automatic logic [rmo_pkg::WORD_W-1:0] word_update(
		input logic [rmo_pkg::WORD_W-1:0] cur,
		input logic [rmo_pkg::WORD_W-1:0] nv,
		input logic                       por,
		input logic                       srst,
		input logic                       hit,
		input logic [rmo_pkg::WORD_W-1:0] data,
		input logic                       kp,
		input logic                       kr
	);
		word_update = cur;
		if (por) begin
			if (kp) begin
				word_update = nv; // [R9]
			end else begin
				word_update = rmo_pkg::RST_WORD; // [R8]
			end
		end else if (srst) begin
			if (!kr) begin
				word_update = rmo_pkg::RST_WORD; // [R10]
			end
		end else if (hit) begin
			word_update = data; // [R11] [R12]
		end
	endfunction : word_update

	////////////////////////////////////////////////////////////////////////
	// only the four retention codes are taken; others leave the select unchanged
	assign sel_ok   = sel_valid(reg_wdata); // [R1]
	assign keep_pwr = sel_keeps_power(retention_select);
	assign keep_rst = sel_keeps_reset(retention_select);
	// host writes move the words only once the sequencer runs, so a late write cannot undo a reset
	assign wr_run   = reg_wr && (state == rmo_pkg::RMO_ST_RUN); // [R11]
	assign wr_one   = wr_run && (reg_addr == rmo_pkg::REG_WORD_ONE);
	assign wr_two   = wr_run && (reg_addr == rmo_pkg::REG_WORD_TWO);
	assign fitted = {{rmo_pkg::RLY_N{relay_fitted}}, {rmo_pkg::EXT_N{ext_fitted}}};

	////////////////////////////////////////////////////////////////////////
	// retention select lives in nonvolatile parameter space; rst_n is the
	// hardware reset only and returns it to its initial value
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			retention_select <= rmo_pkg::RST_SEL;
		end else if (reg_wr && reg_addr == rmo_pkg::REG_SEL && sel_ok) begin
			retention_select <= reg_wdata[rmo_pkg::SEL_W-1:0]; // [R1]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer: reset requests hold the block until words are settled
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= rmo_pkg::RMO_ST_RESET;
		end else if (power_on_reset || soft_reset) begin
			state <= rmo_pkg::RMO_ST_RESET;
		end else begin
			case (state)
				rmo_pkg::RMO_ST_RESET: begin
					state <= rmo_pkg::RMO_ST_RESTORE;
				end
				rmo_pkg::RMO_ST_RESTORE: begin
					state <= rmo_pkg::RMO_ST_RUN; // [R13]
				end
				default: begin
					state <= rmo_pkg::RMO_ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ready <= 1'b0;
		end else begin
			ready <= (state == rmo_pkg::RMO_ST_RUN) && !power_on_reset && !soft_reset;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data words; write protection is deliberately not consulted
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			remote_word_one <= rmo_pkg::RST_WORD; // [R2]
		end else begin
			remote_word_one <= word_update(remote_word_one, nv_word_one, power_on_reset,
				soft_reset, wr_one, reg_wdata, keep_pwr, keep_rst);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			remote_word_two <= rmo_pkg::RST_WORD; // [R2]
		end else begin
			remote_word_two <= word_update(remote_word_two, nv_word_two, power_on_reset,
				soft_reset, wr_two, reg_wdata, keep_pwr, keep_rst);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// one save pulse on the rising edge of power_fail, only while the select keeps words at power loss
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			fail_d  <= 1'b0;
			nv_save <= 1'b0;
		end else begin
			fail_d  <= power_fail;
			nv_save <= power_fail && !fail_d && keep_pwr; // [R9]
		end
	end

	////////////////////////////////////////////////////////////////////////
	rmo_term_map #(
		.TERM_W (rmo_pkg::TERM_W)
	) u_map (
		.word_one    (remote_word_one),
		.word_two    (remote_word_two),
		.func_sel    (output_terminal_assign),
		.func_level  (assigned_func_level),
		.fitted      (fitted),
		.next_assign (next_assign),
		.next_term   (next_term)
	);

	// terminals register next_assign every cycle, so values are settled before ready
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			assigned_terminals <= '0;
		end else begin
			assigned_terminals <= next_assign; // [R13]
		end
	end

	// option outputs stay low while their hardware is absent, whatever the words hold
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			extension_outputs <= '0;
		end else begin
			extension_outputs <= next_term[rmo_pkg::EXT_LSB +: rmo_pkg::EXT_N]; // [R3]
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			relay_outputs <= '0;
		end else begin
			relay_outputs <= next_term[rmo_pkg::RLY_LSB +: rmo_pkg::RLY_N]; // [R4]
		end
	end

	logic unused_wp;
	assign unused_wp = write_protect_select;
endmodule : rmo_ctrl

// file: logic/rmo_term_map.sv
// module: per-terminal output selection between remote words and assigned function
`timescale 1ns/1ns
module rmo_term_map #(
	parameter int TERM_W = rmo_pkg::TERM_W
) (
	input  wire logic [rmo_pkg::WORD_W-1:0]   word_one,
	input  wire logic [rmo_pkg::WORD_W-1:0]   word_two,
	input  wire logic [rmo_pkg::FUNC_W-1:0]   func_sel [rmo_pkg::N_ASSIGN],
	input  wire logic [rmo_pkg::N_ASSIGN-1:0] func_level,
	input  wire logic [TERM_W-1:0]            fitted,
	output logic      [rmo_pkg::N_ASSIGN-1:0] next_assign,
	output logic      [TERM_W-1:0]            next_term
);
	function automatic logic is_remote(input logic [rmo_pkg::FUNC_W-1:0] f);
		is_remote = (f == rmo_pkg::FUNC_REM_POS) || (f == rmo_pkg::FUNC_REM_NEG);
	endfunction : is_remote

	logic [TERM_W-1:0] bits;
	// the two words are both remote output images; either one turns a bit on
	assign bits = fitted & (word_one[TERM_W-1:0] | word_two[TERM_W-1:0]); // [R3] [R4]

	always_comb begin
		for (int i = 0; i < rmo_pkg::N_ASSIGN; i++) begin
			if (is_remote(func_sel[i])) begin // [R5]
				// assigned terminal i follows bit i; negative logic inverts [R6]
				next_assign[i] = bits[i] ^ (func_sel[i] == rmo_pkg::FUNC_REM_NEG);
			end else begin
				next_assign[i] = func_level[i]; // [R7]
			end
		end
		next_term = bits; // [R3] [R4]
	end
endmodule : rmo_term_map

// file: shared/rmo_pkg.sv
// package: constants for the remote output control block
package rmo_pkg;
	localparam int          WORD_W           = 12;
	localparam int          SEL_W            = 8;
	localparam int          TERM_W           = 10;
	localparam int          FUNC_W           = 8;
	localparam int          N_ASSIGN         = 3;
	localparam int          EXT_LSB          = 0;
	localparam int          EXT_N            = 7;
	localparam int          RLY_LSB          = 7;
	localparam int          RLY_N            = 3;
	localparam logic [7:0]  SEL_CLR_ALL      = 8'h00;
	localparam logic [7:0]  SEL_KEEP_PWR     = 8'h01;
	localparam logic [7:0]  SEL_KEEP_RST     = 8'h0a;
	localparam logic [7:0]  SEL_KEEP_BOTH    = 8'h0b;
	localparam logic [7:0]  FUNC_REM_POS     = 8'h60;
	localparam logic [7:0]  FUNC_REM_NEG     = 8'hc4;
	localparam logic [7:0]  RST_SEL          = 8'h00;
	localparam logic [11:0] RST_WORD         = 12'h000;
	localparam logic [1:0]  REG_SEL          = 2'h0;
	localparam logic [1:0]  REG_WORD_ONE     = 2'h1;
	localparam logic [1:0]  REG_WORD_TWO     = 2'h2;
	typedef enum logic [1:0] {
		RMO_ST_RESET   = 2'b00,
		RMO_ST_RESTORE = 2'b01,
		RMO_ST_RUN     = 2'b10
	} rmo_state_t;
endpackage : rmo_pkg
